// ==== src/bemf_stall_detection_config.v ====
// Back-emf stall detection configuration, gating, flags and observation mode.
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "bemf_stall_defs.vh"

module bemf_stall_detection_config #(
    parameter       BEMF_W  = 8,
    parameter       POS_W   = 16,
    parameter [6:0] I2C_ADDR = `I2C_SLAVE_ADDR
) (
    // Clock and reset
    input  wire              sys_clk_i,
    input  wire              srst_i,
    // Register port
    input  wire [3:0]        reg_addr_i,
    input  wire [31:0]       reg_wdata_i,
    input  wire              reg_wr_i,
    input  wire              reg_rd_i,
    output reg  [31:0]       reg_rdata_o,
    // Serial bus pins
    input  wire              scl_i,
    input  wire              sda_i,
    output wire              sda_o,
    output wire              sda_oe_o,
    // Motion and PWM status from the controller
    input  wire              pwm_cycle_i,
    input  wire              fullstep_i,
    input  wire              at_max_velocity_i,
    input  wire              positioning_i,
    input  wire              pwm_full_duty_i,
    input  wire [BEMF_W-1:0] bemf_value_i,
    input  wire [BEMF_W-1:0] bemf_average_i,
    input  wire [BEMF_W-1:0] bemf_integrator_i,
    input  wire [POS_W-1:0]  internal_position_i,
    // Switch pin
    input  wire              switch_input_pin_i,
    output reg               switch_analog_en_o,
    output reg  [BEMF_W-1:0] switch_analog_level_o,
    output reg               switch_state_o,
    // Results
    output reg               hard_stop_o,
    output reg               pwm_rate_select_o,
    output reg  [POS_W-1:0]  actual_position_o,
    output wire              irq_o
);
    localparam integer ABS_STEP = `ABS_STEP_LSB;
    localparam integer DEL_STEP = `DEL_STEP_LSB;

    reg  [3:0]              absolute_stall_threshold;
    reg  [3:0]              delta_stall_threshold;
    reg  [2:0]              bemf_sample_delay;
    reg  [2:0]              stall_arm_fullstep_delay;
    reg                     full_duty_stall_suppress;
    reg                     observe_mode;
    reg  [`ST_WIDTH-1:0]    status;
    reg  [`ST_WIDTH-1:0]    mask;
    reg  [`ST_WIDTH-1:0]    next_status;
    reg  [`ST_WIDTH-1:0]    status_set;
    reg  [`ST_WIDTH-1:0]    status_clr;
    reg                     sw_sync1;
    reg                     sw_sync2;
    reg                     vmax_q;
    reg                     armed;
    reg  [2:0]              fs_cnt;
    reg  [3:0]              pwm_cnt;
    reg                     sampled;
    reg                     sample_strobe;
    reg  [2:0]              byte_idx;
    reg  [7:0]              opcode;
    reg  [BEMF_W:0]         abs_level;
    reg  [BEMF_W:0]         del_level;
    reg                     hit_hi;
    reg                     hit_lo;
    reg                     hit_abs;

    wire [7:0]              rx_byte;
    wire                    rx_valid;
    wire                    rx_first;
    wire                    frame_end;
    wire                    detect_en;
    wire                    suppressed;
    wire                    evaluate;
    wire                    stall_hit;
    wire [3:0]              sample_target;
    wire [BEMF_W:0]         bemf_ext;
    wire [BEMF_W:0]         avg_ext;

    // addressed slave for command reception and status readback.
    i2c_cmd_slave #(
        .SLAVE_ADDR (I2C_ADDR)
    ) u_slave (
        .sys_clk_i   (sys_clk_i),
        .srst_i      (srst_i),
        .scl_i       (scl_i),
        .sda_i       (sda_i),
        .sda_o       (sda_o),
        .sda_oe_o    (sda_oe_o),
        .rx_byte_o   (rx_byte),
        .rx_valid_o  (rx_valid),
        .rx_first_o  (rx_first),
        .frame_end_o (frame_end),
        .tx_byte_i   ({2'b00, status})
    );

    assign detect_en  = (absolute_stall_threshold != 4'h0) || (delta_stall_threshold != 4'h0);
    assign suppressed = full_duty_stall_suppress & pwm_full_duty_i;
    assign evaluate   = sample_strobe & armed & detect_en & ~suppressed & at_max_velocity_i & positioning_i;
    assign stall_hit  = evaluate & (hit_hi | hit_lo | hit_abs);
    assign bemf_ext   = {1'b0, bemf_value_i};
    assign avg_ext    = {1'b0, bemf_average_i};
    assign sample_target = {1'b0, bemf_sample_delay} + `SAMPLE_BASE_CYC;
    assign irq_o      = |(status & mask);

    // threshold decode, common scale of the back-emf word.
    always @* begin
        abs_level = absolute_stall_threshold * ABS_STEP[BEMF_W:0];
        del_level = delta_stall_threshold * DEL_STEP[BEMF_W:0];
    end

    // comparisons against the moving average and the absolute floor.
    always @* begin
        hit_hi  = (delta_stall_threshold != 4'h0) && (bemf_ext > avg_ext + del_level);
        hit_lo  = (delta_stall_threshold != 4'h0) && (bemf_ext + del_level < avg_ext);
        hit_abs = (absolute_stall_threshold != 4'h0) && (bemf_ext < abs_level);
    end

    // switch pin sampling, blanked while observing.
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            sw_sync1       <= 1'b0;
            sw_sync2       <= 1'b0;
            switch_state_o <= 1'b0;
        end else begin
            sw_sync1       <= switch_input_pin_i;
            sw_sync2       <= sw_sync1;
            switch_state_o <= observe_mode ? 1'b0 : sw_sync2;
        end
    end

    // analog output on the switch pin.
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            switch_analog_en_o    <= 1'b0;
            switch_analog_level_o <= {BEMF_W{1'b0}};
        end else begin
            switch_analog_en_o    <= observe_mode;
            switch_analog_level_o <= observe_mode ? bemf_integrator_i : {BEMF_W{1'b0}};
        end
    end

    // sample delay in PWM cycles after each full step.
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            pwm_cnt       <= 4'h0;
            sampled       <= 1'b0;
            sample_strobe <= 1'b0;
        end else begin
            sample_strobe <= 1'b0;
            if (fullstep_i) begin
                pwm_cnt <= 4'h0;
                sampled <= 1'b0;
            end else if (pwm_cycle_i && !sampled) begin
                pwm_cnt <= pwm_cnt + 4'h1;
                if (pwm_cnt + 4'h1 == sample_target) begin
                    sampled       <= 1'b1;
                    sample_strobe <= 1'b1;
                end
            end
        end
    end

    // arming after the ramp plus extra full steps.
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            vmax_q <= 1'b0;
            armed  <= 1'b0;
            fs_cnt <= 3'h0;
        end else begin
            vmax_q <= at_max_velocity_i;
            if (!at_max_velocity_i || !detect_en) begin
                armed  <= 1'b0;
                fs_cnt <= 3'h0;
            end else if (!vmax_q) begin
                armed  <= (stall_arm_fullstep_delay == 3'h0);
                fs_cnt <= 3'h0;
            end else if (fullstep_i && !armed) begin
                fs_cnt <= fs_cnt + 3'h1;
                armed  <= (fs_cnt + 3'h1 >= stall_arm_fullstep_delay);
            end
        end
    end

    // hard stop and position capture on a stall.
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            hard_stop_o       <= 1'b0;
            actual_position_o <= {POS_W{1'b0}};
        end else begin
            hard_stop_o <= stall_hit;
            if (stall_hit) begin
                actual_position_o <= internal_position_i;
            end
        end
    end

    // Sticky flags: an event in the clearing cycle keeps its bit set.
    always @* begin
        status_set                = {`ST_WIDTH{1'b0}};
        status_set[`ST_DELTA_HI]  = evaluate & hit_hi;
        status_set[`ST_DELTA_LO]  = evaluate & hit_lo;
        status_set[`ST_ABS]       = evaluate & hit_abs;
        status_set[`ST_STALL]     = stall_hit;
        status_set[`ST_STEP_LOSS] = stall_hit;
        status_set[`ST_OBSERVE]   = rx_valid & rx_first & (rx_byte == `CMD_BEMF_OBSERVE) & ~observe_mode;
        status_clr = (reg_wr_i && reg_addr_i == `REG_STATUS) ? reg_wdata_i[`ST_WIDTH-1:0] : {`ST_WIDTH{1'b0}};
        next_status = (status & ~status_clr) | status_set;
    end

    // Configuration from the register port and from serial commands.
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            absolute_stall_threshold <= `RST_THR;
            delta_stall_threshold    <= `RST_THR;
            bemf_sample_delay        <= `RST_DLY;
            stall_arm_fullstep_delay <= `RST_DLY;
            full_duty_stall_suppress <= 1'b0;
            pwm_rate_select_o        <= 1'b0;
            observe_mode             <= 1'b0;
            status                   <= `RST_STATUS;
            mask                     <= `RST_STATUS;
            byte_idx                 <= 3'h0;
            opcode                   <= 8'h00;
        end else begin
            status <= next_status;
            if (reg_wr_i && reg_addr_i == `REG_CONFIG) begin
                absolute_stall_threshold <= reg_wdata_i[`CFG_ABS_MSB:`CFG_ABS_LSB];
                delta_stall_threshold    <= reg_wdata_i[`CFG_DEL_MSB:`CFG_DEL_LSB];
                bemf_sample_delay        <= reg_wdata_i[`CFG_SMP_MSB:`CFG_SMP_LSB];
                stall_arm_fullstep_delay <= reg_wdata_i[`CFG_FS_MSB:`CFG_FS_LSB];
                full_duty_stall_suppress <= reg_wdata_i[`CFG_SUPPRESS];
                pwm_rate_select_o        <= reg_wdata_i[`CFG_PWM_RATE];
            end
            if (reg_wr_i && reg_addr_i == `REG_MASK) begin
                mask <= reg_wdata_i[`ST_WIDTH-1:0];
            end
            if (frame_end) begin
                byte_idx <= 3'h0;
            end else if (rx_valid && rx_first) begin
                opcode   <= rx_byte;
                byte_idx <= 3'h1;
                // observation entry, never left except by reset
                if (rx_byte == `CMD_BEMF_OBSERVE) begin
                    observe_mode <= 1'b1;
                end
            end else if (rx_valid && byte_idx != 3'h0) begin
                byte_idx <= (byte_idx == 3'h7) ? 3'h0 : byte_idx + 3'h1;
                if (opcode == `CMD_STALL_PARAM) begin
                    if (byte_idx == `SP_THR_BYTE) begin
                        absolute_stall_threshold <= rx_byte[7:4];
                        delta_stall_threshold    <= rx_byte[3:0];
                    end
                    if (byte_idx == `SP_DLY_BYTE) begin
                        bemf_sample_delay        <= rx_byte[7:5];
                        stall_arm_fullstep_delay <= rx_byte[2:0];
                    end
                    // suppress bit from the last data byte
                    if (byte_idx == `SP_FLAG_BYTE) begin
                        full_duty_stall_suppress <= rx_byte[`SP_SUPPRESS_BIT];
                    end
                end
            end
        end
    end

    // Read data stand for exactly one cycle after the strobe.
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            reg_rdata_o <= 32'h00000000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `REG_CONFIG: begin
                    reg_rdata_o <= {14'h0000, pwm_rate_select_o, full_duty_stall_suppress, 1'b0,
                                    stall_arm_fullstep_delay, 1'b0, bemf_sample_delay,
                                    delta_stall_threshold, absolute_stall_threshold};
                end
                `REG_STATUS: begin
                    reg_rdata_o <= {26'h0000000, status};
                end
                `REG_MASK: begin
                    reg_rdata_o <= {26'h0000000, mask};
                end
                `REG_STATE: begin
                    reg_rdata_o <= {28'h0000000, detect_en, switch_state_o, observe_mode, armed};
                end
                `REG_ACTUAL_POS: begin
                    reg_rdata_o <= {{(32-POS_W){1'b0}}, actual_position_o};
                end
                default: begin
                    reg_rdata_o <= 32'h00000000;
                end
            endcase
        end else begin
            reg_rdata_o <= 32'h00000000;
        end
    end
endmodule // bemf_stall_detection_config
`default_nettype wire

// ==== src/bemf_stall_defs.vh ====
// Shared constants for the back-emf stall detection block.
`ifndef BEMF_STALL_DEFS_VH
`define BEMF_STALL_DEFS_VH

// Register word indices on the register port.
`define REG_CONFIG      4'h0
`define REG_STATUS      4'h1
`define REG_MASK        4'h2
`define REG_STATE       4'h3
`define REG_ACTUAL_POS  4'h4

// Config register field positions.
`define CFG_ABS_LSB     0
`define CFG_ABS_MSB     3
`define CFG_DEL_LSB     4
`define CFG_DEL_MSB     7
`define CFG_SMP_LSB     8
`define CFG_SMP_MSB     10
`define CFG_FS_LSB      12
`define CFG_FS_MSB      14
`define CFG_SUPPRESS    16
`define CFG_PWM_RATE    17

// Status, mask and interrupt bit positions.
`define ST_DELTA_LO     0
`define ST_DELTA_HI     1
`define ST_ABS          2
`define ST_STALL        3
`define ST_STEP_LOSS    4
`define ST_OBSERVE      5
`define ST_WIDTH        6

// Reset values.
`define RST_THR         4'h0
`define RST_DLY         3'h0
`define RST_STATUS      6'h00

// Threshold scale: one LSB of the back-emf word is 0.125 V.
`define ABS_STEP_MV     500
`define DEL_STEP_MV     250
`define BEMF_LSB_MV     125
`define ABS_STEP_LSB    (`ABS_STEP_MV / `BEMF_LSB_MV)
`define DEL_STEP_LSB    (`DEL_STEP_MV / `BEMF_LSB_MV)

// Sample delay: index 0 is two PWM periods, each index adds one.
`define SAMPLE_BASE_CYC 4'h2

// Serial interface commands and stall parameter byte positions.
`define CMD_STALL_PARAM 8'h96
`define CMD_BEMF_OBSERVE 8'h9f
`define I2C_SLAVE_ADDR  7'h60
`define SP_THR_BYTE     3'h5
`define SP_DLY_BYTE     3'h6
`define SP_FLAG_BYTE    3'h7
`define SP_SUPPRESS_BIT 1

// Spike filter on the serial lines.
`define CLK_PERIOD_NS   8
`define SPIKE_NS        50
`define SPIKE_CYC       ((`SPIKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== src/i2c_cmd_slave.v ====
// Byte-level serial bus slave with spike filtering, used for stall commands.
`timescale 1ns/1ps
`default_nettype none
`include "bemf_stall_defs.vh"

module i2c_cmd_slave #(
    parameter [6:0] SLAVE_ADDR = `I2C_SLAVE_ADDR
) (
    // Clock and reset
    input  wire       sys_clk_i,
    input  wire       srst_i,
    // Bus pins
    input  wire       scl_i,
    input  wire       sda_i,
    output wire       sda_o,
    output wire       sda_oe_o,
    // Byte side
    output reg  [7:0] rx_byte_o,
    output reg        rx_valid_o,
    output reg        rx_first_o,
    output reg        frame_end_o,
    input  wire [7:0] tx_byte_i
);
    localparam [5:0] S_IDLE = 6'b000001;
    localparam [5:0] S_ADDR = 6'b000010;
    localparam [5:0] S_ACK  = 6'b000100;
    localparam [5:0] S_RX   = 6'b001000;
    localparam [5:0] S_TX   = 6'b010000;
    localparam [5:0] S_TACK = 6'b100000;
    localparam integer SPIKE_N = `SPIKE_CYC - 1;
    localparam [3:0] SPIKE_LAST = SPIKE_N[3:0];

    reg  [1:0] sync1;
    reg  [1:0] sync2;
    wire [1:0] filt;
    reg  [1:0] filt_q;
    reg  [5:0] state;
    reg  [7:0] shift;
    reg  [3:0] cnt;
    reg        rw;
    reg        drive;
    reg        first;

    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            sync1 <= 2'h3;
            sync2 <= 2'h3;
        end else begin
            sync1 <= {scl_i, sda_i};
            sync2 <= sync1;
        end
    end

    // spike rejection: a level must hold several clocks before it is taken.
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_filt
            reg [3:0] run;
            reg       lvl;
            assign filt[g] = lvl;
            always @(posedge sys_clk_i) begin
                if (srst_i) begin
                    run <= 4'h0;
                    lvl <= 1'b1;
                end else if (sync2[g] == lvl) begin
                    run <= 4'h0;
                end else if (run == SPIKE_LAST) begin
                    lvl <= sync2[g];
                    run <= 4'h0;
                end else begin
                    run <= run + 4'h1;
                end
            end
        end
    endgenerate

    wire scl      = filt[1];
    wire sda      = filt[0];
    wire scl_rise = scl & ~filt_q[1];
    wire scl_fall = ~scl & filt_q[1];
    wire start    = scl & filt_q[1] & ~sda & filt_q[0];
    wire stop     = scl & filt_q[1] & sda & ~filt_q[0];

    // slave only: the pin is driven low, never high, and only when addressed.
    assign sda_o    = 1'b0;
    assign sda_oe_o = drive;

    // byte framing: eight bits MSB first, then one acknowledge bit.
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            filt_q      <= 2'h3;
            state       <= S_IDLE;
            shift       <= 8'h00;
            cnt         <= 4'h0;
            rw          <= 1'b0;
            drive       <= 1'b0;
            first       <= 1'b0;
            rx_byte_o   <= 8'h00;
            rx_valid_o  <= 1'b0;
            rx_first_o  <= 1'b0;
            frame_end_o <= 1'b0;
        end else begin
            filt_q      <= filt;
            rx_valid_o  <= 1'b0;
            frame_end_o <= 1'b0;
            if (start) begin
                state <= S_ADDR;
                cnt   <= 4'h0;
                drive <= 1'b0;
            end else if (stop) begin
                if (state != S_IDLE) begin
                    frame_end_o <= 1'b1;
                end
                state <= S_IDLE;
                drive <= 1'b0;
            end else if (scl_rise) begin
                if ((state == S_ADDR) || (state == S_RX)) begin
                    shift <= {shift[6:0], sda};
                    cnt   <= cnt + 4'h1;
                end else if ((state == S_TACK) && sda) begin
                    state <= S_IDLE;
                end
            end else if (scl_fall) begin
                case (state)
                    S_ADDR: begin
                        if (cnt == 4'h8) begin
                            cnt <= 4'h0;
                            if (shift[7:1] == SLAVE_ADDR) begin
                                rw    <= shift[0];
                                first <= 1'b1;
                                drive <= 1'b1;
                                state <= S_ACK;
                            end else begin
                                state <= S_IDLE;
                            end
                        end
                    end
                    S_RX: begin
                        if (cnt == 4'h8) begin
                            cnt        <= 4'h0;
                            rx_byte_o  <= shift;
                            rx_first_o <= first;
                            rx_valid_o <= 1'b1;
                            first      <= 1'b0;
                            drive      <= 1'b1;
                            state      <= S_ACK;
                        end
                    end
                    S_ACK, S_TACK: begin
                        if (rw) begin
                            shift <= tx_byte_i;
                            drive <= ~tx_byte_i[7];
                            cnt   <= 4'h1;
                            state <= S_TX;
                        end else begin
                            drive <= 1'b0;
                            state <= S_RX;
                        end
                    end
                    S_TX: begin
                        if (cnt == 4'h8) begin
                            drive <= 1'b0;
                            state <= S_TACK;
                        end else begin
                            shift <= {shift[6:0], 1'b0};
                            drive <= ~shift[6];
                            cnt   <= cnt + 4'h1;
                        end
                    end
                    default: begin
                        drive <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule // i2c_cmd_slave
`default_nettype wire

// ==== testbench/bemf_stall_properties.sv ====
// Port assertions for the stall detection block.
`timescale 1ns/1ps
`default_nettype none
module bemf_stall_properties #(parameter POS_W = 16) (
    // Watched ports
    input wire logic             sys_clk_i,
    input wire logic             srst_i,
    input wire logic             sda_o,
    input wire logic             pwm_cycle_i,
    input wire logic             at_max_velocity_i,
    input wire logic             positioning_i,
    input wire logic [POS_W-1:0] internal_position_i,
    input wire logic [POS_W-1:0] actual_position_o,
    input wire logic             hard_stop_o,
    input wire logic             switch_analog_en_o,
    input wire logic             switch_state_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    a_stop_pulse: assert property (hard_stop_o |=> !hard_stop_o) else $error("stop too long");
    a_stop_pos: assert property (hard_stop_o |-> actual_position_o == $past(internal_position_i))
        else $error("position not copied");
    a_stop_vmax: assert property (hard_stop_o |-> $past(at_max_velocity_i)) else $error("stop while ramping");
    a_stop_moving: assert property (hard_stop_o |-> $past(positioning_i)) else $error("stop while idle");
    a_stop_sample: assert property (hard_stop_o |-> $past(pwm_cycle_i, 2)) else $error("stop off sample");
    a_observe_held: assert property (switch_analog_en_o |=> switch_analog_en_o) else $error("observe left");
    a_observe_blind: assert property (switch_analog_en_o |=> !switch_state_o) else $error("switch read");
    a_open_drain: assert property (sda_o == 1'b0) else $error("data driven high");
    cover property (hard_stop_o);
    cover property ($rose(switch_analog_en_o));
    cover property (at_max_velocity_i && pwm_cycle_i);
endmodule // bemf_stall_properties
bind bemf_stall_detection_config bemf_stall_properties #(.POS_W(POS_W)) chk_i (.*);
`default_nettype wire

// ==== testbench/i2c_master_model.sv ====
// Serial bus master model that sends command frames.
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
    // Clock and device pull-down
    input  wire logic clk_i,
    input  wire logic pull_i,
    // Bus lines
    output var  logic scl_o = 1'b1,
    output wire logic sda_o
);
    logic drv = 1'b1, gl = 1'b0;
    assign sda_o = drv & ~pull_i & ~gl;
    task automatic step(input logic c, input logic d);
        scl_o <= c;
        drv <= d;
        repeat (80) @(posedge clk_i);
    endtask
    task automatic seq(input int n, input logic [5:0] s);
        for (int k = n - 1; k >= 0; k--) step(s[2*k+1], s[2*k]);
    endtask
    // Eight bits, acknowledge slot, short spike.
    task automatic put(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= -1; i--) begin
            step(1'b0, i < 0 || b[i & 7]);
            step(1'b1, i < 0 || b[i & 7]);
            ack = ~sda_o;
            gl <= 1'b1;
            repeat (3) @(posedge clk_i);
            gl <= 1'b0;
            step(1'b1, i < 0 || b[i & 7]);
            step(1'b0, i < 0 || b[i & 7]);
        end
    endtask
endmodule // i2c_master_model
`default_nettype wire

// ==== testbench/bemf_stall_detection_config_tb.sv ====
// Self-checking bench for the stall detection block.
`timescale 1ns/1ps
`default_nettype none
module bemf_stall_detection_config_tb;
    logic        sys_clk_i = 1'b0, srst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, pwm_cycle_i = 1'b0;
    logic        fullstep_i = 1'b0, at_max_velocity_i = 1'b0, positioning_i = 1'b1, pwm_full_duty_i = 1'b0;
    logic        switch_input_pin_i = 1'b0;
    logic [3:0]  reg_addr_i = 4'h0;
    logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, seed = 32'h94ab;
    logic [7:0]  bemf_value_i = 8'h0, bemf_average_i = 8'h0, bemf_integrator_i = 8'h0, switch_analog_level_o, fq[$];
    logic [15:0] internal_position_i = 16'h0, actual_position_o;
    wire         scl_i, sda_i, sda_o, sda_oe_o, switch_analog_en_o, switch_state_o, hard_stop_o, pwm_rate_select_o, irq_o;
    int          fail_count = 0, tests_run = 0, stops = 0;
    i2c_master_model m (.clk_i(sys_clk_i), .pull_i(sda_oe_o), .scl_o(scl_i), .sda_o(sda_i));
    bemf_stall_detection_config DUT (.*);
    always #4 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) bemf_integrator_i <= bemf_integrator_i + 8'h3;
    always @(posedge sys_clk_i) stops <= stops + (hard_stop_o === 1'b1);
    function automatic logic [31:0] rnd;
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= w;
        reg_rd_i <= ~w;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        @(posedge sys_clk_i);
        q = reg_rdata_o;
    endtask
    task automatic tick(input logic f);
        @(posedge sys_clk_i);
        fullstep_i <= f;
        pwm_cycle_i <= ~f;
        @(posedge sys_clk_i);
        fullstep_i <= 1'b0;
        pwm_cycle_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask
    task automatic send;
        logic ak;
        m.seq(2, 6'h08);
        foreach (fq[j]) begin
            m.put(fq[j], ak);
            chk("ack", fq[0] == 8'hc0, ak);
        end
        m.seq(3, 6'h0b);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge sys_clk_i);
        fail_count++;
        results;
    end
    initial begin
        logic [31:0] r, v, q;
        int lo, hi, sa, dl, ex, s0;
        repeat (8) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        repeat (10) @(posedge sys_clk_i);
        for (int a = 0; a < 16; a += 3) begin
            bus(1'b0, a[3:0], 32'h0, q);
            chk("reset", 32'h0, q);
        end
        fq = '{8'hc0, 8'h96, 8'h00, 8'h00, 8'h00, 8'h00, 8'h5a, 8'h66, 8'h02};
        send;
        bus(1'b0, 4'h0, 32'h0, q);
        chk("config", 32'h163a5, q & 32'h177ff);
        fq = '{8'h80};
        send;
        $display("test serial done");
        bus(1'b1, 4'h2, 32'h8, q);
        for (int i = 0; i < 16; i++) begin
            r = rnd() & 32'h11377ff;
            v = rnd();
            dl = r[7:4];
            lo = dl != 0 && v[7:0] + 2 * dl < v[15:8];
            hi = dl != 0 && v[7:0] > v[15:8] + 2 * dl;
            sa = r[3:0] != 0 && v[7:0] < 4 * r[3:0];
            ex = (lo || hi || sa) && !(r[16] && r[20]) && !r[24];
            bus(1'b1, 4'h0, r & 32'h377ff, q);
            chk("rate", r[17], pwm_rate_select_o);
            bemf_value_i <= v[7:0];
            bemf_average_i <= v[15:8];
            internal_position_i <= v[31:16];
            pwm_full_duty_i <= r[20];
            positioning_i <= ~r[24];
            at_max_velocity_i <= 1'b1;
            repeat (r[14:12] + 1) tick(1'b1);
            s0 = stops;
            repeat (r[10:8] + 2) tick(1'b0);
            repeat (2) @(posedge sys_clk_i);
            chk("stop", ex, stops - s0);
            if (ex) chk("position", v[31:16], actual_position_o);
            chk("irq", ex, irq_o);
            bus(1'b0, 4'h1, 32'h0, q);
            chk("status", ex ? 32'h18 | sa << 2 | hi << 1 | lo : 32'h0, q);
            bus(1'b1, 4'h1, 32'h3f, q);
            at_max_velocity_i <= 1'b0;
            @(posedge sys_clk_i);
            chk("irq_clear", 32'h0, irq_o);
        end
        $display("test stall done");
        switch_input_pin_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        chk("switch", 32'h1, switch_state_o);
        fq = '{8'hc0, 8'h9f};
        send;
        bus(1'b0, 4'h1, 32'h0, q);
        chk("observe", 32'h20, q);
        chk("analog", 32'h1, switch_analog_en_o);
        chk("level", 8'(bemf_integrator_i - 8'h3), switch_analog_level_o);
        chk("switch", 32'h0, switch_state_o);
        fq = '{8'hc0, 8'h96};
        send;
        chk("analog", 32'h1, switch_analog_en_o);
        $display("test observe done");
        results;
    end
endmodule // bemf_stall_detection_config_tb
`default_nettype wire
